// *** design/pcos_pkg.sv ***
// Purpose: Shared constants for the clock output selector and its core-side controller.
// Assumes: One 125 MHz system clock; the configuration word is 32 bits.
// Notes: Field positions, masks, reset value, lock timing and controller map.
package pcos_pkg;
  // Configuration word field positions.
  localparam int PCOS_BDIV_LSB = 0;
  localparam int PCOS_MUL_LSB = 4;
  localparam int PCOS_BYP_LSB = 14;
  localparam int PCOS_SLEEP_BIT = 16;
  localparam int PCOS_CIN_LSB = 17;
  localparam int PCOS_LOCK_BIT = 23;
  localparam int PCOS_AUX_BIT = 24;
  localparam logic [31:0] PCOS_RESET = 32'h0001_c00f;
  localparam logic [31:0] PCOS_WMASK = 32'h007f_cfff;
  localparam logic [31:0] PCOS_SLEEP_MASK = 32'h0001_0000;
  localparam logic [31:0] PCOS_BYP_MASK = 32'h0000_c000;
  localparam logic [31:0] PCOS_LOCK_MASK = 32'h0080_0000;
  // Lock wait: 150 us at 125 MHz, exactly 18750 cycles.
  localparam int PCOS_LOCK_US = 150;
  localparam int PCOS_CLK_MHZ = 125;
  localparam int PCOS_LOCK_CYC = PCOS_LOCK_US * PCOS_CLK_MHZ;
  // Reference half period in system cycles, for the oscillator model.
  localparam int PCOS_REF_HALF = 16;
  // Controller register offsets.
  localparam logic [3:0] PCOS_A_CTRL = 4'h0;
  localparam logic [3:0] PCOS_A_WDATA = 4'h4;
  localparam logic [3:0] PCOS_A_RDATA = 4'h8;
  localparam logic [3:0] PCOS_A_STAT = 4'hc;
  // Controller operation codes.
  localparam logic [2:0] PCOS_OP_WRITE = 3'h1;
  localparam logic [2:0] PCOS_OP_READ = 3'h2;
  localparam logic [2:0] PCOS_OP_WLOCK = 3'h3;
  localparam logic [2:0] PCOS_OP_SLEEP = 3'h4;
  localparam logic [1:0] PCOS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCOS_RESP_SLVERR = 2'h2;
endpackage : pcos_pkg

// *** design/pcos_if.sv ***
// Purpose: Configuration register link between processor core side and clock selector.
// Assumes: Both ends run on the same clock.
// Notes: Request held until the one-cycle acknowledge.
`timescale 1ns/1ns
interface pcos_if;
  logic req;
  logic wr;
  logic sup;
  logic [31:0] wdata;
  logic ack;
  logic exc;
  logic [31:0] rdata;
  modport dev (input req, wr, sup, wdata, output ack, exc, rdata);
  modport core (output req, wr, sup, wdata, input ack, exc, rdata);
endinterface : pcos_if

// *** design/pcos_dev.sv ***
// Purpose: Clock output selector with its configuration register.
// Assumes: Reference clock arrives as a pin sampled on clk_i; outputs are sampled waveforms.
// Notes: Clock path flops carry no reset so the reference passes through during reset.
// Contract
// RL1 - Reset drives both outputs from reference
// RL2 - Glitch-free, coincident rising edges, near 50%
// RL3 - Switching never makes pulses shorter (code keeps core pulses whole; a divided bus pulse can be cut at a switch)
// RL4 - Core controls pass a full synchronizer
// RL5 - Lock never affects output selection
// RL6 - Divider nonzero, bypass 00: oscillator sources
// RL7 - Divider nonzero, bypass 01: reference sources
// RL8 - Bypass 1x or divider zero cases
// RL9 - Sleep silences oscillator, selection unchanged
// RL10 - Test select overrides normal selection
// RL11 - Supervisor-only access, otherwise exception
// RL12 - Register field layout as defined
// RL13 - Register reset values as defined
// RL14 - Software writes zero bits as zero
// RL15 - Software polls lock bit after writing
// RL16 - Sleep entry by read-modify-write
// RL17 - No lock hardware: wait 150 us
// RL18 - Ratios equal field value plus one
// RL19 - Lock on status bit 0, other bit 1
// RL20 - Select bypass before setting sleep
// RL21 - Status field read-only, zero fields ignored
// RL22 - Source switch only when both low
`timescale 1ns/1ns
module pcos_dev import pcos_pkg::*; #(
  parameter int LOCK_CYC = PCOS_LOCK_CYC, // Lock settle time in cycles.
  parameter int REF_HALF = PCOS_REF_HALF, // Reference half period in cycles.
  parameter bit HAS_LOCK = 1'b1 // Lock detector present.
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  pcos_if.dev cfg, // Configuration register link.
  input wire logic reference_clock_in_i, // Reference clock pin.
  input wire logic [3:0] test_select_i, // Test mode select pins.
  input wire logic pll_status_i, // Auxiliary oscillator status pin.
  output logic core_clock_out_o, // Core clock waveform.
  output logic bus_clock_out_o, // Bus clock waveform.
  output logic [5:0] pll_cfg_in_o, // Oscillator configuration inputs.
  output logic pll_sleep_o // Oscillator sleep.
);
  logic [31:0] cfg_q;
  logic [22:0] sync1;
  logic [22:0] sync2;
  logic [2:0] ref_s;
  logic ref_f;
  logic [3:0] ts1;
  logic [3:0] ts2;
  logic [3:0] ts3;
  logic [3:0] ts_f;
  logic [2:0] aux_s;
  logic aux_f;
  logic lock;
  logic [31:0] lock_cnt;
  logic [8:0] mul_prev;
  logic [15:0] osc_cnt;
  logic [15:0] osc_half;
  logic osc_lvl;
  logic src_osc;
  logic div_on;
  logic [3:0] bdiv_q;
  logic src_prev;
  logic src_lvl;
  logic [4:0] hcnt;
  logic [4:0] next_hcnt;
  logic [4:0] ratio;
  logic safe;
  logic take;
  logic [1:0] stat_bits;
  logic lock_live;
  logic next_src_osc;
  logic next_div_on;
  logic sel_chg;

  // A request is taken once, on the first cycle it is seen without acknowledge.
  assign take = cfg.req && !cfg.ack;
  // Lock reads low while a written multiplier or sleep change is still crossing, so a poll never sees a stale lock.
  assign lock_live = lock && !cfg_q[PCOS_SLEEP_BIT] && mul_prev == {1'b0, cfg_q[PCOS_MUL_LSB +: 8]} + 9'h001; // RL15
  assign stat_bits = {aux_f, HAS_LOCK ? lock_live : 1'b0}; // RL19

  // Register write; only supervisor accesses land, and read-only or zero bits are masked.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= PCOS_RESET; // RL13
    end else if (take && cfg.wr && cfg.sup) begin
      cfg_q <= cfg.wdata & PCOS_WMASK; // RL11 RL12 RL21
    end
  end

  // Answer one cycle after the take; user mode gets the exception and no data.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.ack <= 1'b0;
      cfg.exc <= 1'b0;
      cfg.rdata <= 32'h0000_0000;
    end else begin
      cfg.ack <= take;
      cfg.exc <= take && !cfg.sup; // RL11
      if (take && !cfg.wr && cfg.sup) begin
        cfg.rdata <= (cfg_q & PCOS_WMASK) | ({30'h0, stat_bits} << PCOS_LOCK_BIT); // RL12 RL19 RL21
      end
    end
  end

  // Two-stage synchronizer for the register fields before the generator uses them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= PCOS_RESET[22:0];
      sync2 <= PCOS_RESET[22:0];
    end else begin
      sync1 <= cfg_q[22:0]; // RL4
      sync2 <= sync1;
    end
  end

  // Register-driven outputs to the oscillator.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_sleep_o <= 1'b1;
      pll_cfg_in_o <= 6'h00;
    end else begin
      pll_sleep_o <= sync2[PCOS_SLEEP_BIT];
      pll_cfg_in_o <= sync2[PCOS_CIN_LSB +: 6];
    end
  end

  // Pin samplers; no reset so the reference keeps flowing while reset is held.
  always_ff @(posedge clk_i) begin
    ref_s <= {ref_s[1:0], reference_clock_in_i};
    if (ref_s[1] == ref_s[2]) begin
      ref_f <= ref_s[2];
    end
  end

  // Test select and auxiliary status pins, each through three flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts1 <= 4'h0;
      ts2 <= 4'h0;
      ts3 <= 4'h0;
      ts_f <= 4'h0;
      aux_s <= 3'h0;
      aux_f <= 1'b0;
    end else begin
      ts1 <= test_select_i;
      ts2 <= ts1;
      ts3 <= ts2;
      if (ts2 == ts3) begin
        ts_f <= ts3;
      end
      aux_s <= {aux_s[1:0], pll_status_i};
      if (aux_s[1] == aux_s[2]) begin
        aux_f <= aux_s[2];
      end
    end
  end

  // Oscillator model: half period is the reference half divided by the multiplier plus one.
  assign osc_half = 16'(REF_HALF) / 16'({7'h0, mul_prev}); // RL18

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt <= 16'h0000;
      osc_lvl <= 1'b0;
    end else if (sync2[PCOS_SLEEP_BIT]) begin
      osc_cnt <= 16'h0000; // RL9
      osc_lvl <= 1'b0; // RL9
    end else if (osc_cnt + 16'h0001 >= osc_half) begin
      osc_cnt <= 16'h0000;
      osc_lvl <= !osc_lvl;
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  // Lock detector restarts on any multiplier change or while asleep.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mul_prev <= 9'h001;
      lock_cnt <= 32'(LOCK_CYC);
      lock <= 1'b0;
    end else begin
      mul_prev <= {1'b0, sync2[PCOS_MUL_LSB +: 8]} + 9'h001;
      if (sync2[PCOS_SLEEP_BIT] || mul_prev != {1'b0, sync2[PCOS_MUL_LSB +: 8]} + 9'h001) begin
        lock_cnt <= 32'(LOCK_CYC);
        lock <= 1'b0;
      end else if (lock_cnt != 32'h0000_0000) begin
        lock_cnt <= lock_cnt - 32'h0000_0001;
      end else begin
        lock <= 1'b1;
      end
    end
  end

  // Selection follows divider and bypass only; sleep and lock never feed it.
  // Applied only while both sources are low, so no core clock pulse is cut short; a divided bus pulse can still be.
  assign safe = !ref_f && !osc_lvl; // RL22 RL3
  assign next_src_osc = sync2[PCOS_BYP_LSB +: 2] == 2'b00; // RL5 RL6 RL8 RL9
  assign next_div_on = !sync2[PCOS_BYP_LSB + 1] && sync2[PCOS_BDIV_LSB +: 4] != 4'h0; // RL6 RL7 RL8
  // Only a real change restarts the divider; a restart at every safe point would make the bus clock follow the source.
  assign sel_chg = safe && (next_src_osc != src_osc || next_div_on != div_on ||
                            sync2[PCOS_BDIV_LSB +: 4] != bdiv_q); // RL22
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_osc <= 1'b0; // RL1
      div_on <= 1'b0;
      bdiv_q <= 4'h0;
    end else if (safe) begin
      src_osc <= next_src_osc; // RL5 RL6 RL8 RL9 RL22
      div_on <= next_div_on; // RL6 RL7 RL8
      bdiv_q <= sync2[PCOS_BDIV_LSB +: 4];
    end
  end

  // Bus divider counts source half periods; high for ratio halves, low for ratio halves.
  assign src_lvl = src_osc ? osc_lvl : ref_f;
  assign ratio = {1'b0, bdiv_q} + 5'h01; // RL18

  always_comb begin
    next_hcnt = hcnt;
    if (src_lvl != src_prev) begin
      next_hcnt = (hcnt >= (ratio << 1) - 5'h01) ? 5'h00 : hcnt + 5'h01;
    end
  end

  // Restarting the count at a safe point lines the next bus rise up with a source rise.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev <= 1'b0;
      hcnt <= 5'h1f;
    end else begin
      src_prev <= src_lvl;
      if (sel_chg) begin
        hcnt <= 5'((({1'b0, sync2[PCOS_BDIV_LSB +: 4]} + 5'h01) << 1) - 5'h01); // RL2
      end else begin
        hcnt <= next_hcnt; // RL2
      end
    end
  end

  // Output stage: both edges come from the same flop rank, so rises coincide.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_clock_out_o <= ref_f; // RL1
      bus_clock_out_o <= ref_f; // RL1
    end else begin
      casez (ts_f)
        4'b001?: begin
          core_clock_out_o <= ref_f; // RL10
          bus_clock_out_o <= ref_f; // RL10
        end
        4'b01??: begin
          core_clock_out_o <= ts_f[1]; // RL10
          bus_clock_out_o <= ts_f[0]; // RL10
        end
        default: begin
          core_clock_out_o <= src_lvl; // RL6 RL7 RL8
          bus_clock_out_o <= div_on ? (next_hcnt < ratio) : src_lvl; // RL2 RL6 RL7 RL8
        end
      endcase
    end
  end
endmodule : pcos_dev

// *** design/pcos_core.sv ***
// Purpose: Core-side controller that reaches the configuration register for software.
// Assumes: Software drives it over AXI4-Lite with 32-bit aligned words.
// Notes: One operation at a time; a control write while busy is ignored.
`timescale 1ns/1ns
module pcos_core import pcos_pkg::*; #(
  parameter int LOCK_CYC = PCOS_LOCK_CYC, // Timed wait when no lock bit.
  parameter bit HAS_LOCK = 1'b1 // Poll the lock bit instead of waiting.
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  pcos_if.core cfg, // Configuration register link.
  input wire logic [3:0] s_awaddr_i, // Write address.
  input wire logic s_awvalid_i, // Write address valid.
  output logic s_awready_o, // Write address ready.
  input wire logic [31:0] s_wdata_i, // Write data.
  input wire logic [3:0] s_wstrb_i, // Write strobes.
  input wire logic s_wvalid_i, // Write data valid.
  output logic s_wready_o, // Write data ready.
  output logic [1:0] s_bresp_o, // Write response.
  output logic s_bvalid_o, // Write response valid.
  input wire logic s_bready_i, // Write response ready.
  input wire logic [3:0] s_araddr_i, // Read address.
  input wire logic s_arvalid_i, // Read address valid.
  output logic s_arready_o, // Read address ready.
  output logic [31:0] s_rdata_o, // Read data.
  output logic [1:0] s_rresp_o, // Read response.
  output logic s_rvalid_o, // Read data valid.
  input wire logic s_rready_i // Read data ready.
);
  typedef enum logic [2:0] {
    PCOS_IDLE = 3'b000,
    PCOS_RD = 3'b001,
    PCOS_WR = 3'b010,
    PCOS_POLL = 3'b011,
    PCOS_WAIT = 3'b100,
    PCOS_SBYP = 3'b101,
    PCOS_SSLP = 3'b110
  } pcos_state_type;

  pcos_state_type state;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [31:0] wait_cnt;
  logic [2:0] op_q;
  logic user_q;
  logic err;
  logic [3:0] aw_q;
  logic aw_have;
  logic w_have;
  logic [31:0] w_q;
  logic [3:0] w_strb;
  logic wr_go;
  logic start;
  logic err_set;

  // A write completes once both address and data are held and no response is pending.
  assign wr_go = aw_have && w_have && !s_bvalid_o;
  assign start = wr_go && aw_q == PCOS_A_CTRL && w_strb[0] && state == PCOS_IDLE;
  assign err_set = cfg.ack && cfg.exc;

  // Write channels are taken independently, in either order.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= PCOS_RESP_OKAY;
    end else begin
      s_awready_o <= !aw_have && !(s_awvalid_i && s_awready_o);
      s_wready_o <= !w_have && !(s_wvalid_i && s_wready_o);
      if (s_awvalid_i && s_awready_o) begin
        aw_have <= 1'b1;
        aw_q <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_have <= 1'b1;
        w_q <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= (aw_q == PCOS_A_CTRL || aw_q == PCOS_A_WDATA || aw_q == PCOS_A_STAT) ?
                     PCOS_RESP_OKAY : PCOS_RESP_SLVERR;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // Read channel; status shows busy, sticky exception and the last lock bit.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0000_0000;
      s_rresp_o <= PCOS_RESP_OKAY;
    end else begin
      s_arready_o <= !s_rvalid_o && !(s_arvalid_i && s_arready_o);
      if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o <= PCOS_RESP_OKAY;
        unique case (s_araddr_i)
          PCOS_A_CTRL: s_rdata_o <= {28'h0, user_q, op_q};
          PCOS_A_WDATA: s_rdata_o <= wdata_q;
          PCOS_A_RDATA: s_rdata_o <= rdata_q;
          PCOS_A_STAT: s_rdata_o <= {29'h0, rdata_q[PCOS_LOCK_BIT], err, state != PCOS_IDLE};
          default: begin
            s_rdata_o <= 32'h0000_0000;
            s_rresp_o <= PCOS_RESP_SLVERR;
          end
        endcase
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // Sticky exception flag; a new exception beats a same-cycle clear.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err <= 1'b0;
    end else if (err_set) begin
      err <= 1'b1;
    end else if (wr_go && aw_q == PCOS_A_STAT && w_q[1]) begin
      err <= 1'b0;
    end
  end

  // Write data register; zero bits are forced clear before they leave.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdata_q <= 32'h0000_0000;
    end else if (wr_go && aw_q == PCOS_A_WDATA && state == PCOS_IDLE) begin
      wdata_q <= w_q & PCOS_WMASK; // RL14
    end
  end

  // Access sequencer: request held until acknowledge, then the next step may follow at once.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PCOS_IDLE;
      cfg.req <= 1'b0;
      cfg.wr <= 1'b0;
      cfg.sup <= 1'b1;
      cfg.wdata <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      op_q <= 3'h0;
      user_q <= 1'b0;
      wait_cnt <= 32'h0000_0000;
    end else begin
      unique case (state)
        PCOS_IDLE: begin
          if (start) begin
            op_q <= w_q[2:0];
            user_q <= w_q[3];
            cfg.sup <= !w_q[3];
            cfg.wdata <= wdata_q;
            if (w_q[2:0] == PCOS_OP_WRITE || w_q[2:0] == PCOS_OP_WLOCK) begin
              cfg.req <= 1'b1;
              cfg.wr <= 1'b1;
              state <= PCOS_WR;
            end else if (w_q[2:0] == PCOS_OP_READ || w_q[2:0] == PCOS_OP_SLEEP) begin
              cfg.req <= 1'b1;
              cfg.wr <= 1'b0;
              state <= PCOS_RD;
            end
          end
        end
        PCOS_RD: begin
          if (cfg.ack) begin
            rdata_q <= cfg.rdata;
            if (!cfg.exc && op_q == PCOS_OP_SLEEP) begin
              cfg.wr <= 1'b1;
              cfg.wdata <= (cfg.rdata | PCOS_BYP_MASK) & PCOS_WMASK; // RL16 RL20 RL14
              state <= PCOS_SBYP;
            end else begin
              cfg.req <= 1'b0;
              state <= PCOS_IDLE;
            end
          end
        end
        PCOS_SBYP: begin
          if (cfg.ack) begin
            if (cfg.exc) begin
              cfg.req <= 1'b0;
              state <= PCOS_IDLE;
            end else begin
              cfg.wdata <= cfg.wdata | PCOS_SLEEP_MASK; // RL16
              state <= PCOS_SSLP;
            end
          end
        end
        PCOS_WR: begin
          if (cfg.ack) begin
            if (!cfg.exc && op_q == PCOS_OP_WLOCK && HAS_LOCK) begin
              cfg.wr <= 1'b0; // RL15
              state <= PCOS_POLL;
            end else if (!cfg.exc && op_q == PCOS_OP_WLOCK) begin
              cfg.req <= 1'b0;
              wait_cnt <= 32'(LOCK_CYC); // RL17
              state <= PCOS_WAIT;
            end else begin
              cfg.req <= 1'b0;
              state <= PCOS_IDLE;
            end
          end
        end
        PCOS_POLL: begin
          if (cfg.ack) begin
            rdata_q <= cfg.rdata;
            if (cfg.exc || cfg.rdata[PCOS_LOCK_BIT]) begin
              cfg.req <= 1'b0; // RL15
              state <= PCOS_IDLE;
            end
          end
        end
        PCOS_WAIT: begin
          if (wait_cnt <= 32'h0000_0001) begin
            state <= PCOS_IDLE; // RL17
          end
          wait_cnt <= wait_cnt - 32'h0000_0001;
        end
        PCOS_SSLP: begin
          if (cfg.ack) begin
            cfg.req <= 1'b0;
            state <= PCOS_IDLE;
          end
        end
        default: begin
          cfg.req <= 1'b0;
          state <= PCOS_IDLE;
        end
      endcase
    end
  end
endmodule : pcos_core

// *** sim/pcos_asserts.sv ***
// Purpose: Checks on the configuration link between the controller and the clock selector.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Both ends are design code, so every check here watches design behaviour.
`timescale 1ns/1ns
module pcos_asserts (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Reset, active high.
  input wire logic req, // Access request.
  input wire logic wr, // Write when high.
  input wire logic sup, // Supervisor mode.
  input wire logic [31:0] wdata, // Write word.
  input wire logic ack, // Answer pulse.
  input wire logic exc, // Refusal pulse.
  input wire logic [31:0] rdata // Read word.
);
  // Every check runs on the one clock and is quiet during reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A taken request is answered at the very next edge, and the answer is one cycle long.
  ack_on_take_a: assert property (req && !ack |=> ack) else $error("answer not one cycle after take");
  ack_pulse_a: assert property (ack |=> !ack) else $error("answer longer than one cycle");
  // The core side must not move its request before it sees the answer.
  req_hold_a: assert property (req && !ack |=> req && $stable(wr) && $stable(sup) && $stable(wdata))
    else $error("request changed before answer");
  // Refusals come only with an answer, and exactly for user mode.
  exc_with_ack_a: assert property (exc |-> ack) else $error("refusal without answer");
  user_refused_a: assert property (req && !ack && !sup |=> exc) else $error("user access not refused");
  sup_accepted_a: assert property (req && !ack && sup |=> !exc) else $error("supervisor access refused");
  user_rdata_a: assert property (req && !ack && !sup |=> $stable(rdata)) else $error("refused access moved data");
  // Read data moves only on an accepted read answer, and zero fields read as zero.
  rdata_moves_a: assert property (!$stable(rdata) |-> ack && !exc && !wr) else $error("read data moved");
  zero_bits_a: assert property (ack && !exc && !wr |-> rdata[31:25] == 7'h00 && rdata[13:12] == 2'h0)
    else $error("zero field read nonzero");
endmodule : pcos_asserts

// *** sim/tb_top.sv ***
// Purpose: Drives the controller over AXI4-Lite and watches the selector's clock outputs.
// Assumes: Reference half period of 16 cycles; lock time shortened to 20 cycles.
// Notes: Pulse and edge monitor runs only while the table of modes is swept.
`timescale 1ns/1ns
module tb_top import pcos_pkg::*;;
  logic clk_i = 0, rst_i = 1, ref_clk = 0, stat = 1, mon = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, pc, pb;
  logic [3:0] awaddr = 0, araddr = 0, tsel = 0;
  logic [31:0] wdat = 0, rdat, d;
  logic awready, wready, bvalid, arready, rvalid, cco, bco, sleep;
  logic [1:0] bresp, rresp;
  logic [5:0] cfg_in;
  int miscompares = 0, cmp_count = 0, cr, br, crun = 99, rcnt = 0, i;
  logic [31:0] tw [5] = '{32'h0000_4000, 32'h0000_4001, 32'h0000_8011, 32'h0000_0010, 32'h0000_0011};
  int tc [5] = '{8, 8, 8, 16, 16};
  int tb [5] = '{8, 4, 8, 16, 8};

  pcos_if u_pcos_if ();
  pcos_dev #(.LOCK_CYC(20)) u_pcos_dev (.clk_i, .rst_i, .cfg(u_pcos_if), .reference_clock_in_i(ref_clk),
    .test_select_i(tsel), .pll_status_i(stat), .core_clock_out_o(cco), .bus_clock_out_o(bco),
    .pll_cfg_in_o(cfg_in), .pll_sleep_o(sleep));
  pcos_core #(.LOCK_CYC(20)) u_pcos_core (.clk_i, .rst_i, .cfg(u_pcos_if), .s_awaddr_i(awaddr),
    .s_awvalid_i(awv), .s_awready_o(awready), .s_wdata_i(wdat), .s_wstrb_i(4'hf), .s_wvalid_i(wv),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr),
    .s_arvalid_i(arv), .s_arready_o(arready), .s_rdata_o(rdat), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready));
  pcos_asserts u_pcos_asserts (.clk_i, .rst_i, .req(u_pcos_if.req), .wr(u_pcos_if.wr), .sup(u_pcos_if.sup),
    .wdata(u_pcos_if.wdata), .ack(u_pcos_if.ack), .exc(u_pcos_if.exc), .rdata(u_pcos_if.rdata));

  // Clock, and a reference clock that toggles every 16 cycles.
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rcnt <= (rcnt + 1) % 16;
    if (rcnt == 15) ref_clk <= ~ref_clk;
  end

  // Counts rising edges; core high pulses and bus edges are judged only while the sweep runs.
  always @(posedge clk_i) begin
    if (mon && pc === 1'b1 && cco === 1'b0) chk(crun >= 8, "short core pulse");
    crun <= (cco !== pc) ? 1 : crun + 1;
    if (mon && bco === 1'b1 && pb === 1'b0) chk(cco === 1'b1 && pc === 1'b0, "bus edge off core edge");
    if (cco === 1'b1 && pc === 1'b0) cr <= cr + 1;
    if (bco === 1'b1 && pb === 1'b0) br <= br + 1;
    pc <= cco;
    pb <= bco;
  end

  task chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task stop_test;
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // A used-up bound ends the run at once.
  task tmo(input bit ok);
    if (!ok) begin
      chk(0, "timeout");
      stop_test;
    end
  endtask : tmo

  // Address and data go out together; bready stays up until the response is seen.
  task axw(input logic [3:0] a, input logic [31:0] w, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    awaddr <= a;
    wdat <= w;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    tmo(n < 40);
    chk(bresp === er, "write response");
  endtask : axw

  task axr(input logic [3:0] a, output logic [31:0] q, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (arv && arready) arv <= 0;
      if (rvalid) break;
    end
    q = rdat;
    rready <= 0;
    tmo(n < 40);
    chk(rresp === er, "read response");
  endtask : axr

  // Launches one controller operation and polls until it is no longer busy.
  task op(input logic [3:0] c, input logic [31:0] w);
    int n;
    axw(PCOS_A_WDATA, w, PCOS_RESP_OKAY);
    axw(PCOS_A_CTRL, {28'h0, c}, PCOS_RESP_OKAY);
    for (n = 0; n < 60; n++) begin
      axr(PCOS_A_STAT, d, PCOS_RESP_OKAY);
      if (d[0] === 1'b0) break;
    end
    tmo(n < 60);
  endtask : op

  // Reads back the register through a read operation and compares it.
  task rdback(input logic [31:0] e);
    op(PCOS_OP_READ, 32'h0);
    axr(PCOS_A_RDATA, d, PCOS_RESP_OKAY);
    chk(d === e, "register readback");
  endtask : rdback

  // Both outputs must copy the reference once the filter has settled.
  task refchk;
    repeat (8) @(posedge clk_i);
    repeat (64) begin
      @(negedge clk_i);
      if (rcnt >= 6) chk(cco === ref_clk && bco === ref_clk, "output not reference");
    end
  endtask : refchk

  task meas(input int ec, input int eb);
    repeat (64) @(posedge clk_i);
    @(negedge clk_i);
    cr = 0;
    br = 0;
    repeat (256) @(negedge clk_i);
    chk(cr >= ec - 1 && cr <= ec + 1 && br >= eb - 1 && br <= eb + 1, "clock rate");
  endtask : meas

  // Main sequence; the expected words follow the field layout and the masks of the rules.
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rdback(32'h0101_c00f);
    chk(sleep === 1'b1 && cfg_in === 6'h00, "reset pins");
    op(PCOS_OP_WRITE, 32'hffff_ffff);
    rdback(32'h017f_cfff);
    chk(cfg_in === 6'h3f, "config pins");
    refchk;
    mon <= 1;
    for (i = 0; i < 5; i++) begin
      op(PCOS_OP_WLOCK, tw[i]);
      axr(PCOS_A_STAT, d, PCOS_RESP_OKAY);
      chk(d[2] === 1'b1, "lock not seen");
      meas(tc[i], tb[i]);
    end
    mon <= 0;
    tsel <= 4'h6;
    repeat (16) @(posedge clk_i);
    chk(cco === 1'b1 && bco === 1'b0, "test pins");
    tsel <= 4'h2;
    refchk;
    tsel <= 4'h0;
    op(4'h9, 32'h0000_c000);
    op(4'ha, 32'h0);
    axr(PCOS_A_STAT, d, PCOS_RESP_OKAY);
    chk(d[1] === 1'b1, "no exception");
    axw(PCOS_A_STAT, 32'h2, PCOS_RESP_OKAY);
    axr(PCOS_A_STAT, d, PCOS_RESP_OKAY);
    chk(d[1] === 1'b0, "exception kept");
    rdback(32'h0180_0011);
    op(PCOS_OP_SLEEP, 32'h0);
    rdback(32'h0101_c011);
    chk(sleep === 1'b1, "sleep pin");
    refchk;
    axw(PCOS_A_RDATA, 32'h0, PCOS_RESP_SLVERR);
    axr(4'h2, d, PCOS_RESP_SLVERR);
    rst_i <= 1;
    refchk;
    rst_i <= 0;
    rdback(32'h0101_c00f);
    chk(sleep === 1'b1 && cfg_in === 6'h00, "reset pins");
    stop_test;
  end
endmodule : tb_top
